// >>> common/pscm_regs.svh
// register offsets, field positions and reset values of the capture block
`ifndef PSCM_REGS_SVH
`define PSCM_REGS_SVH
`define PSCM_OFF_CAP_LOW 8'h00
`define PSCM_OFF_CAP_HIGH 8'h04
`define PSCM_OFF_MATRIX 8'h08
`define PSCM_OFF_IRQ_MASK 8'h0C
`define PSCM_OFF_FLAGS 8'h10
`define PSCM_OFF_CONTROL 8'h14
`define PSCM_BIT_SOFT_TRIG 7
`define PSCM_BIT_ACT_B 7
`define PSCM_BIT_ACT_A 6
`define PSCM_BIT_SYNC_ERR 5
`define PSCM_BIT_EVT_B 4
`define PSCM_BIT_EVT_A 3
`define PSCM_BIT_CYC_END 0
`define PSCM_BIT_ENH_END 1
`define PSCM_BIT_CAP_EN_A 0
`define PSCM_BIT_CAP_EN_B 1
`define PSCM_BIT_FOLLOW 2
`define PSCM_BIT_RUN 3
`define PSCM_MASK_WR 8'h3B
`define PSCM_FLAGS_CLR 8'hF9
`define PSCM_CTRL_WR 8'h0F
`define PSCM_RST_BYTE 8'h00
`define PSCM_RST_CAP 12'h000
`endif

// >>> common/pscm_pkg.sv
// types shared by the capture, matrix and flag block
package pscm_pkg;
  // event strobes from counter, input blocks and master, and the master's run level
  typedef struct packed {
    logic cycle_end;
    logic enh_cycle_end;
    logic event_a;
    logic event_b;
    logic master_cycle_end;
    logic master_run;
  } pscm_evt_s;
  // the four waveform outputs
  typedef struct packed {
    logic wave_out_a_primary;
    logic wave_out_a_alternate;
    logic wave_out_b_primary;
    logic wave_out_b_alternate;
  } pscm_out_s;
  typedef logic [7:0] pscm_byte_t;
  typedef enum logic [1:0] {
    PSCM_RESP_OKAY = 2'b00,
    PSCM_RESP_SLVERR = 2'b10
  } pscm_resp_e;
endpackage

// >>> src/pscm_top.sv
// capture, output matrix and interrupt flags of the power stage controller
//
// How it works
// - writing one to the soft trigger bit captures the counter
// - soft trigger bit reads one when latest capture was software's
// - an enabled part's input event loads the counter into capture
// - capture is 12 bits: high nibble in high byte, low byte apart
// - reading the low byte latches the high byte into one temp byte
// - matrix bits 7..4 give B outputs level in ramps 3..0
// - matrix bits 3..0 give A outputs level in ramps 3..0
// - enabled sync error flag raises the interrupt
// - enabled part A or B events raise the interrupt
// - enabled enhanced cycle end raises interrupt after 15th cycle
// - enabled cycle end raises the interrupt on each whole cycle
// - activity flags set on any change of B or A output
// - sync error set when following a running master and cycle ends disagree
// - event flags set on every event, enabled or not
// - ramp number field records ramp of latest event
// - cycle end flag set on each whole cycle
// - writing one clears a flag, zero leaves it alone
// - a part captures only while its capture enable is set
// - follow bit makes the block run with the master's run
`timescale 1ns/100ps
`include "pscm_regs.svh"
module pscm_top
  import pscm_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // waveform counter side
  input wire logic [11:0] wave_count,
  input wire logic [1:0] ramp,
  input wire pscm_evt_s evt,
  // outputs
  output pscm_out_s wave_out,
  output logic run_active,
  output logic irq
);

  // ==========================================================
  // register state
  logic [11:0] capture_value;
  logic capture_soft_trigger;
  pscm_byte_t temp_high;
  pscm_byte_t ramp_output_matrix;
  pscm_byte_t interrupt_enable_mask;
  pscm_byte_t flag_bits;
  logic [1:0] event_ramp_number;
  logic enh_pending;
  pscm_byte_t control;
  logic out_a;
  logic out_b;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] rd_byte;
  logic rd_ok;
  logic wr_ok;

  // ==========================================================
  // axi write channel
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane0_q;
  logic wr_go;

  // each channel is taken on its own; the write acts once both are held
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  // capture of write address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr_q <= `PSCM_RST_BYTE;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
    end
  end

  // capture of write data; only lane 0 carries register bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data_q <= `PSCM_RST_BYTE;
      w_lane0_q <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // address decode for writes
  always_comb begin
    unique case (aw_addr_q)
      `PSCM_OFF_CAP_LOW, `PSCM_OFF_CAP_HIGH, `PSCM_OFF_MATRIX,
      `PSCM_OFF_IRQ_MASK, `PSCM_OFF_FLAGS, `PSCM_OFF_CONTROL: begin
        wr_ok = 1'b1;
      end
      default: begin
        wr_ok = 1'b0;
      end
    endcase
  end

  // write response; unmapped address answers slverr
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PSCM_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? PSCM_RESP_OKAY : PSCM_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // a lane-0 write to a given offset
  function automatic logic wr_hit(input logic [7:0] off);
    wr_hit = wr_go && w_lane0_q && (aw_addr_q == off);
  endfunction

  // ==========================================================
  // software registers
  logic soft_trig;
  assign soft_trig = wr_hit(`PSCM_OFF_CAP_HIGH) &&
    w_data_q[`PSCM_BIT_SOFT_TRIG];

  // matrix, mask and control bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp_output_matrix <= `PSCM_RST_BYTE;
      interrupt_enable_mask <= `PSCM_RST_BYTE;
      control <= `PSCM_RST_BYTE;
    end else if (ce) begin
      if (wr_hit(`PSCM_OFF_MATRIX)) begin
        ramp_output_matrix <= w_data_q;
      end
      if (wr_hit(`PSCM_OFF_IRQ_MASK)) begin
        interrupt_enable_mask <= w_data_q & `PSCM_MASK_WR;
      end
      if (wr_hit(`PSCM_OFF_CONTROL)) begin
        control <= w_data_q & `PSCM_CTRL_WR;
      end
    end
  end

  // ==========================================================
  // run control: own run bit, or master's run when following
  assign run_active = control[`PSCM_BIT_RUN] ||
    (control[`PSCM_BIT_FOLLOW] && evt.master_run);

  // ==========================================================
  // input capture
  logic cap_a;
  logic cap_b;
  assign cap_a = evt.event_a && control[`PSCM_BIT_CAP_EN_A];
  assign cap_b = evt.event_b && control[`PSCM_BIT_CAP_EN_B];

  // software trigger wins over an event in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capture_value <= `PSCM_RST_CAP;
      capture_soft_trigger <= 1'b0;
    end else if (ce) begin
      if (soft_trig) begin
        capture_value <= wave_count;
        capture_soft_trigger <= 1'b1;
      end else if (cap_a || cap_b) begin
        capture_value <= wave_count;
        capture_soft_trigger <= 1'b0;
      end
    end
  end

  // ==========================================================
  // output matrix; outputs come from flops so the edge is clean
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_a <= 1'b0;
      out_b <= 1'b0;
    end else if (ce) begin
      out_a <= ramp_output_matrix[{1'b0, ramp}];
      out_b <= ramp_output_matrix[{1'b1, ramp}];
    end
  end

  // primary and alternate carry the same level
  assign wave_out.wave_out_a_primary = out_a;
  assign wave_out.wave_out_a_alternate = out_a;
  assign wave_out.wave_out_b_primary = out_b;
  assign wave_out.wave_out_b_alternate = out_b;

  // ==========================================================
  // flag sources
  logic next_out_a;
  logic next_out_b;
  assign next_out_a = ramp_output_matrix[{1'b0, ramp}];
  assign next_out_b = ramp_output_matrix[{1'b1, ramp}];

  // hardware set terms, one per flag bit
  always_comb begin
    flag_set = 8'h00;
    flag_set[`PSCM_BIT_ACT_B] = next_out_b != out_b;
    flag_set[`PSCM_BIT_ACT_A] = next_out_a != out_a;
    flag_set[`PSCM_BIT_SYNC_ERR] = control[`PSCM_BIT_FOLLOW] &&
      evt.master_run &&
      (evt.cycle_end != evt.master_cycle_end);
    flag_set[`PSCM_BIT_EVT_B] = evt.event_b;
    flag_set[`PSCM_BIT_EVT_A] = evt.event_a;
    flag_set[`PSCM_BIT_CYC_END] = evt.cycle_end;
  end

  // write-one-to-clear on clearable bits only
  assign flag_clr = wr_hit(`PSCM_OFF_FLAGS) ?
    (w_data_q & `PSCM_FLAGS_CLR) : 8'h00;

  // sticky flags; a set in the clearing cycle is kept
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          flag_bits[gi] <= 1'b0;
        end else if (ce) begin
          if (flag_set[gi]) begin
            flag_bits[gi] <= 1'b1;
          end else if (flag_clr[gi]) begin
            flag_bits[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ramp of the latest event, coded ramp 1..4 as 0..3
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      event_ramp_number <= 2'h0;
    end else if (ce && (evt.event_a || evt.event_b)) begin
      event_ramp_number <= ramp;
    end
  end

  // enhanced cycle end has no visible flag bit; it is pending
  // internally and cleared together with the cycle end flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enh_pending <= 1'b0;
    end else if (ce) begin
      if (evt.enh_cycle_end) begin
        enh_pending <= 1'b1;
      end else if (flag_clr[`PSCM_BIT_CYC_END]) begin
        enh_pending <= 1'b0;
      end
    end
  end

  // ==========================================================
  // interrupt request, a level while any enabled source is set
  always_comb begin
    irq = (flag_bits[`PSCM_BIT_SYNC_ERR] &&
      interrupt_enable_mask[`PSCM_BIT_SYNC_ERR]) ||
      (flag_bits[`PSCM_BIT_EVT_B] &&
      interrupt_enable_mask[`PSCM_BIT_EVT_B]) ||
      (flag_bits[`PSCM_BIT_EVT_A] &&
      interrupt_enable_mask[`PSCM_BIT_EVT_A]) ||
      (enh_pending &&
      interrupt_enable_mask[`PSCM_BIT_ENH_END]) ||
      (flag_bits[`PSCM_BIT_CYC_END] &&
      interrupt_enable_mask[`PSCM_BIT_CYC_END]);
  end

  // ==========================================================
  // axi read channel
  logic rd_take;
  logic low_read;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign low_read = rd_take && (s_axi_araddr == `PSCM_OFF_CAP_LOW);

  // read mux; unused bits of each byte are zero
  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      `PSCM_OFF_CAP_LOW: begin
        rd_byte = capture_value[7:0];
      end
      `PSCM_OFF_CAP_HIGH: begin
        rd_byte = temp_high;
      end
      `PSCM_OFF_MATRIX: begin
        rd_byte = ramp_output_matrix;
      end
      `PSCM_OFF_IRQ_MASK: begin
        rd_byte = interrupt_enable_mask;
      end
      `PSCM_OFF_FLAGS: begin
        rd_byte = {flag_bits[7:3], event_ramp_number,
          flag_bits[0]};
      end
      `PSCM_OFF_CONTROL: begin
        rd_byte = control;
      end
      default: begin
        rd_byte = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  // a low byte read freezes the high byte so the pair is coherent
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      temp_high <= `PSCM_RST_BYTE;
    end else if (ce && low_read) begin
      temp_high <= {capture_soft_trigger, 3'b000,
        capture_value[11:8]};
    end
  end

  // read data register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PSCM_RESP_OKAY;
    end else if (ce) begin
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_ok ? PSCM_RESP_OKAY : PSCM_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> dv/pscm_sva.sv
// port assertions for the capture, matrix and flag block
`timescale 1ns/100ps
// ==========
// checker
module pscm_sva
  import pscm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // core side
  input wire logic [1:0] ramp,
  input wire pscm_evt_s evt,
  input wire pscm_out_s wave_out,
  input wire logic run_active,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // a read request taken on this edge
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // both pins of a leg carry the same matrix level
  AST_OUT_A: assert property (
    wave_out.wave_out_a_primary == wave_out.wave_out_a_alternate)
    else $error("a pins differ");
  AST_OUT_B: assert property (
    wave_out.wave_out_b_primary == wave_out.wave_out_b_alternate)
    else $error("b pins differ");
  // outputs move only after a ramp change or a register write
  AST_WAVE_CAUSE: assert property (
    !$stable(wave_out) |-> $past(ramp) != $past(ramp, 2) ||
      ($past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)))
    else $error("outputs moved without cause");
  // irq rises only after a source pulse or a mask write
  AST_IRQ_RISE: assert property (
    $rose(irq) |-> $rose(s_axi_bvalid) || ($past(evt) & 6'h3E) != 6'h00)
    else $error("irq rose without cause");
  AST_IRQ_FALL: assert property (
    $fell(irq) |-> $rose(s_axi_bvalid))
    else $error("irq fell without a write");
  AST_RUN_RISE: assert property (
    $rose(run_active) |-> $rose(s_axi_bvalid) || $rose(evt.master_run))
    else $error("run started without cause");
  // bus answers stand until taken
  AST_RD_ANSWER: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read not answered");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
endmodule
bind pscm_top pscm_sva u_sva (
  .clk, .rst, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .ramp, .evt,
  .wave_out, .run_active, .irq
);

// >>> dv/pscm_stage_model.sv
// power stage model that counts switching on the gate drive pins
`timescale 1ns/100ps
// ==========
// power stage
module pscm_stage_model
  import pscm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // gate drive from the block
  input wire pscm_out_s wave_out,
  // switching counts seen by the stage
  output int edges_a,
  output int edges_b
);
  pscm_out_s last;
  // a stage only reacts to level changes, so count them per leg
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last <= '0;
      edges_a <= 0;
      edges_b <= 0;
    end else begin
      last <= wave_out;
      if (wave_out[3] != last[3]) edges_a <= edges_a + 1;
      if (wave_out[1] != last[1]) edges_b <= edges_b + 1;
    end
  end
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the capture, matrix and flag block
`timescale 1ns/100ps
`include "pscm_regs.svh"
// ==========
// bench top
module tb_top
  import pscm_pkg::*;
;
  logic clk = 0, rst = 1, ce = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, run_active, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [11:0] wave_count = 0;
  logic [1:0] ramp = 0;
  pscm_evt_s evt = '0;
  pscm_out_s wave_out;
  int mismatches = 0, compares = 0, edges_a, edges_b;
  pscm_byte_t rd_v, m = 8'hA5;
  pscm_byte_t mk[6] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'h20};
  pscm_evt_s pl[6] = '{6'h21, 6'h11, 6'h09, 6'h05, 6'h21, 6'h23};
  logic ex[6] = '{1, 1, 1, 1, 1, 0};
  pscm_top DUT (.clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wave_count, .ramp,
    .evt, .wave_out, .run_active, .irq);
  pscm_stage_model u_stage (.clk, .rst, .wave_out, .edges_a, .edges_b);
  // 50 MHz clock
  always #10 clk = ~clk;
  // compare and count
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // readies and answers are read at the rising edge that takes them
  task wr(input logic [7:0] a, input pscm_byte_t d);
    logic da;
    logic dw;
    da = 0;
    dw = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(da && dw)) begin
      @(posedge clk);
      if (s_axi_awready) da = 1;
      if (s_axi_wready) dw = 1;
      if (da) s_axi_awvalid <= 0;
      if (dw) s_axi_wvalid <= 0;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rc(input logic [7:0] a, input pscm_byte_t e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (!s_axi_rvalid);
    rd_v = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 0;
    chk8(rd_v, e);
  endtask
  // one-cycle strobe, master run level kept
  task pulse(input pscm_evt_s p);
    @(posedge clk);
    evt <= p;
    @(posedge clk);
    evt <= p & 6'h01;
    repeat (2) @(posedge clk);
  endtask
  task give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 6; i++) rc(8'(4 * i), 8'h00);
    rc(8'h40, 8'h00);
    chk8({6'h00, resp}, {6'h00, PSCM_RESP_SLVERR});
    wr(8'h40, 8'hFF);
    chk8({6'h00, resp}, {6'h00, PSCM_RESP_SLVERR});
    wr(`PSCM_OFF_IRQ_MASK, 8'hFF);
    rc(`PSCM_OFF_IRQ_MASK, 8'h3B);
    wave_count <= 12'hABC;
    wr(`PSCM_OFF_CAP_HIGH, 8'h80);
    rc(`PSCM_OFF_CAP_LOW, 8'hBC);
    rc(`PSCM_OFF_CAP_HIGH, 8'h8A);
    wave_count <= 12'h5A5;
    wr(`PSCM_OFF_CAP_HIGH, 8'h80);
    rc(`PSCM_OFF_CAP_HIGH, 8'h8A);
    wr(`PSCM_OFF_CAP_LOW, 8'hFF);
    rc(`PSCM_OFF_CAP_LOW, 8'hA5);
    ramp <= 2'd2;
    wr(`PSCM_OFF_CONTROL, 8'h01);
    wr(`PSCM_OFF_FLAGS, 8'hFF);
    wave_count <= 12'h123;
    pulse(6'h08);
    rc(`PSCM_OFF_CAP_LOW, 8'h23);
    rc(`PSCM_OFF_CAP_HIGH, 8'h01);
    rc(`PSCM_OFF_FLAGS, 8'h0C);
    wave_count <= 12'h456;
    pulse(6'h04);
    rc(`PSCM_OFF_CAP_LOW, 8'h23);
    rc(`PSCM_OFF_FLAGS, 8'h1C);
    ramp <= 2'd0;
    wr(`PSCM_OFF_FLAGS, 8'hFF);
    wr(`PSCM_OFF_MATRIX, m);
    for (int r = 0; r < 4; r++) begin
      ramp <= 2'(r);
      repeat (2) @(posedge clk);
      chk8({4'h0, wave_out}, {4'h0, {2{m[r]}}, {2{m[4 + r]}}});
    end
    // the stage model counts one edge after the output moves
    @(posedge clk);
    chk8(8'(edges_a), 8'h04);
    chk8(8'(edges_b), 8'h03);
    // a write without lane 0 must leave the matrix alone
    s_axi_wstrb <= 4'hE;
    wr(`PSCM_OFF_MATRIX, 8'h00);
    s_axi_wstrb <= 4'hF;
    rc(`PSCM_OFF_MATRIX, m);
    // clock enable low freezes the outputs although the ramp moves
    ce <= 0;
    ramp <= 2'd0;
    repeat (3) @(posedge clk);
    chk8({4'h0, wave_out}, {4'h0, {2{m[3]}}, {2{m[7]}}});
    ce <= 1;
    ramp <= 2'd3;
    rc(`PSCM_OFF_FLAGS, 8'hC4);
    wr(`PSCM_OFF_FLAGS, 8'h40);
    rc(`PSCM_OFF_FLAGS, 8'h84);
    wr(`PSCM_OFF_CONTROL, 8'h04);
    evt <= 6'h01;
    repeat (2) @(posedge clk);
    chk1(run_active, 1'b1);
    // one case per interrupt source, last one is a matched cycle end
    for (int i = 0; i < 6; i++) begin
      wr(`PSCM_OFF_FLAGS, 8'hFF);
      wr(`PSCM_OFF_IRQ_MASK, mk[i]);
      chk1(irq, 1'b0);
      pulse(pl[i]);
      chk1(irq, ex[i]);
      wr(`PSCM_OFF_FLAGS, 8'h00);
      chk1(irq, ex[i]);
      wr(`PSCM_OFF_FLAGS, 8'hFF);
      chk1(irq, 1'b0);
    end
    give_verdict();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule
